// ===== inc/gate_drive_defs.vh
`ifndef GATE_DRIVE_DEFS_VH
`define GATE_DRIVE_DEFS_VH

// Three-level input codes
`define LVL_LOW 2'h0
`define LVL_HIGH 2'h1
`define LVL_TRI 2'h2

// Clock period in ns
`define CLK_PERIOD_NS 4

// Tri-state holdoff, least time, ns
`define TRI_HOLDOFF_NS 150
`define TRI_HOLDOFF_CYC ((`TRI_HOLDOFF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Low-to-high side blanking, ns
`define LH_BLANK_NS 15
`define LH_BLANK_CYC ((`LH_BLANK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// High-to-low side blanking, ns
`define HL_BLANK_NS 13
`define HL_BLANK_CYC ((`HL_BLANK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== rtl/delay_counter.v
`timescale 1ns/1ns
// Counts while run is high; done once count reaches limit
module delay_counter #(
    parameter WIDTH = 8
) (
    input wire clock,
    input wire rstn,
    input wire enable,
    input wire run,
    input wire [WIDTH-1:0] limit,
    output wire done
);

reg [WIDTH-1:0] count_r;
reg [WIDTH-1:0] count_nxt;

always @* begin
    count_nxt = count_r;
    if (!run) begin
        count_nxt = {WIDTH{1'b0}};
    end else if (count_r < limit) begin
        count_nxt = count_r + {{(WIDTH-1){1'b0}}, 1'b1};
    end
end

always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
        count_r <= {WIDTH{1'b0}};
    end else if (enable) begin
        count_r <= count_nxt;
    end
end

assign done = run && (count_r >= limit);

endmodule // delay_counter

// ===== rtl/buck_gate_drive_control.v
// What this block does
// - Both gates stay off until the supply lockout monitor reports release.
// - Tri-state pulse input held past the holdoff turns both gates off, switch node undriven.
// - Tri-state pulse input turns the low gate off at once, the high gate only after a 150 ns holdoff.
// - Mode select high: high gate follows pulse, low gate its complement.
// - Mode select low, pulse low: high off, low on only while current positive.
// - Mode select low, pulse high: high on, low off, as continuous mode.
// - Tri-state mode select forces both gates off whatever the pulse is.
// - Rising pulse: low gate off, wait gate-low flag, blank, then high on.
// - Falling pulse: high gate off, wait switch node low, blank, then low on.
// - High and low gates are never on together.
// - Low-to-high side blanking is about 15 ns.
// - High-to-low side blanking is about 13 ns.
`timescale 1ns/1ns
`include "gate_drive_defs.vh"
module buck_gate_drive_control #(
    parameter CNT_WIDTH = 8,
    parameter [CNT_WIDTH-1:0] TRI_HOLDOFF = `TRI_HOLDOFF_CYC,
    parameter [CNT_WIDTH-1:0] LH_BLANK = `LH_BLANK_CYC,
    parameter [CNT_WIDTH-1:0] HL_BLANK = `HL_BLANK_CYC
) (
    input wire clock,
    input wire rstn,
    input wire clockEnable,
    input wire supplyLockoutReleased,
    input wire [1:0] pulseLevel,
    input wire [1:0] conductionModeSelect,
    input wire lowSideGateBelowThreshold,
    input wire switchNodeBelowThreshold,
    input wire inductorCurrentPositive,
    output reg highSideGate_r,
    output reg lowSideGate_r
);

////////////////////////////////////////////////////////////////////////////////
// States

localparam [2:0] ST_LOCKOUT = 3'h0;
localparam [2:0] ST_OFF = 3'h1;
localparam [2:0] ST_WAIT_LOW_OFF = 3'h2;
localparam [2:0] ST_BLANK_LH = 3'h3;
localparam [2:0] ST_HIGH_ON = 3'h4;
localparam [2:0] ST_WAIT_SW_LOW = 3'h5;
localparam [2:0] ST_BLANK_HL = 3'h6;
localparam [2:0] ST_LOW_SIDE = 3'h7;

reg [2:0] state_r;
reg [2:0] state_nxt;
reg highSideGate_nxt;
reg lowSideGate_nxt;

////////////////////////////////////////////////////////////////////////////////
// Tri-state holdoff and blanking timers

wire pulseTri = (pulseLevel == `LVL_TRI);
wire holdoffDone;
wire blankLhDone;
wire blankHlDone;
wire shutdown;

delay_counter #(.WIDTH(CNT_WIDTH)) holdoffTimer (
    .clock(clock),
    .rstn(rstn),
    .enable(clockEnable),
    .run(pulseTri),
    .limit(TRI_HOLDOFF - {{(CNT_WIDTH-1){1'b0}}, 1'b1}),
    .done(holdoffDone)
);

wire [CNT_WIDTH-1:0] blankLimit = (state_r == ST_BLANK_LH) ? LH_BLANK : HL_BLANK;
wire blankRun = (state_r == ST_BLANK_LH) || (state_r == ST_BLANK_HL);
wire blankDone;

delay_counter #(.WIDTH(CNT_WIDTH)) blankTimer (
    .clock(clock),
    .rstn(rstn),
    .enable(clockEnable),
    .run(blankRun),
    .limit(blankLimit - {{(CNT_WIDTH-1){1'b0}}, 1'b1}),
    .done(blankDone)
);

assign blankLhDone = blankDone && (state_r == ST_BLANK_LH);
assign blankHlDone = blankDone && (state_r == ST_BLANK_HL);

// Tri-state mode or held tri-state pulse forces both gates off
assign shutdown = (conductionModeSelect == `LVL_TRI) || holdoffDone;

////////////////////////////////////////////////////////////////////////////////
// Sequencer

wire pulseHigh = (pulseLevel == `LVL_HIGH);
wire pulseLow = (pulseLevel == `LVL_LOW);
wire ccmMode = (conductionModeSelect == `LVL_HIGH);
wire lowAllowed = ccmMode || inductorCurrentPositive;

always @* begin
    state_nxt = state_r;
    case (state_r)
        ST_LOCKOUT: begin
            if (supplyLockoutReleased) begin
                state_nxt = ST_OFF;
            end
        end
        ST_OFF: begin
            if (pulseHigh) begin
                state_nxt = ST_WAIT_LOW_OFF;
            end else if (pulseLow) begin
                state_nxt = ST_WAIT_SW_LOW;
            end
        end
        ST_WAIT_LOW_OFF: begin
            if (pulseLow) begin
                state_nxt = ST_LOW_SIDE;
            end else if (lowSideGateBelowThreshold) begin
                state_nxt = ST_BLANK_LH;
            end
        end
        ST_BLANK_LH: begin
            if (pulseLow) begin
                state_nxt = ST_LOW_SIDE;
            end else if (blankLhDone) begin
                state_nxt = ST_HIGH_ON;
            end
        end
        ST_HIGH_ON: begin
            if (pulseLow) begin
                state_nxt = ST_WAIT_SW_LOW;
            end
        end
        ST_WAIT_SW_LOW: begin
            if (pulseHigh) begin
                state_nxt = ST_WAIT_LOW_OFF;
            end else if (switchNodeBelowThreshold) begin
                state_nxt = ST_BLANK_HL;
            end
        end
        ST_BLANK_HL: begin
            if (pulseHigh) begin
                state_nxt = ST_WAIT_LOW_OFF;
            end else if (blankHlDone) begin
                state_nxt = ST_LOW_SIDE;
            end
        end
        ST_LOW_SIDE: begin
            if (pulseHigh) begin
                state_nxt = ST_WAIT_LOW_OFF;
            end
        end
        default: begin
            state_nxt = ST_LOCKOUT;
        end
    endcase
    if (!supplyLockoutReleased) begin
        state_nxt = ST_LOCKOUT;
    end else if (shutdown) begin
        state_nxt = ST_OFF;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Gate outputs, decoded from the next state so they are registered

always @* begin
    highSideGate_nxt = (state_nxt == ST_HIGH_ON);
    lowSideGate_nxt = (state_nxt == ST_LOW_SIDE) && lowAllowed && !pulseTri;
    if (highSideGate_nxt) begin
        lowSideGate_nxt = 1'b0;
    end
end

always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
        state_r <= ST_LOCKOUT;
        highSideGate_r <= 1'b0;
        lowSideGate_r <= 1'b0;
    end else if (clockEnable) begin
        state_r <= state_nxt;
        highSideGate_r <= highSideGate_nxt;
        lowSideGate_r <= lowSideGate_nxt;
    end
end

endmodule // buck_gate_drive_control

// ===== test/gate_drive_monitor.sv
`timescale 1ns/1ns
`include "gate_drive_defs.vh"
module gate_drive_monitor (
    input wire clock,
    input wire rstn,
    input wire clockEnable,
    input wire supplyLockoutReleased,
    input wire [1:0] pulseLevel,
    input wire [1:0] conductionModeSelect,
    input wire lowSideGateBelowThreshold,
    input wire switchNodeBelowThreshold,
    input wire inductorCurrentPositive,
    input wire highSideGate_r,
    input wire lowSideGate_r
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    never_both_a: assert property (!(highSideGate_r && lowSideGate_r))
        else $error("gates overlap");
    lockout_off_a: assert property (clockEnable && !supplyLockoutReleased
        |=> !highSideGate_r && !lowSideGate_r) else $error("gate on in lockout");
    mode_tri_a: assert property (clockEnable && conductionModeSelect == `LVL_TRI
        |=> !highSideGate_r && !lowSideGate_r) else $error("gate on in shutdown");
    high_blank_a: assert property ($rose(highSideGate_r)
        |-> $past(lowSideGateBelowThreshold, 4)) else $error("high side early");
    low_blank_a: assert property ($rose(lowSideGate_r)
        |-> $past(switchNodeBelowThreshold, 4)) else $error("low side early");
    high_cause_a: assert property ($rose(highSideGate_r)
        |-> $past(pulseLevel) != `LVL_LOW) else $error("high side without pulse");
    diode_off_a: assert property (clockEnable && conductionModeSelect == `LVL_LOW
        && pulseLevel == `LVL_LOW && !inductorCurrentPositive |=> !lowSideGate_r)
        else $error("low side on with reverse current");
    tri_low_a: assert property (clockEnable && pulseLevel == `LVL_TRI
        |=> !lowSideGate_r) else $error("low side on in tri");
    tri_hold_a: assert property ((clockEnable && pulseLevel == `LVL_TRI) [*5]
        |=> !highSideGate_r) else $error("high side on after holdoff");
    cover property ($rose(highSideGate_r));
    cover property ($rose(lowSideGate_r));
    cover property ((pulseLevel == `LVL_TRI) [*5]);
endmodule // gate_drive_monitor

// ===== test/pwm_controller_model.sv
`timescale 1ns/1ns
`include "gate_drive_defs.vh"
module pwm_controller_model (
    input wire clock,
    input wire rstn,
    input wire deviceReady,
    output reg [1:0] pwmLevel
);
    reg [4:0] phase;
    reg [4:0] duty;
    always @(posedge clock) begin
        if (!rstn || !deviceReady) begin
            phase <= 5'h00;
            duty <= 5'h01;
            pwmLevel <= `LVL_TRI;
        end else begin
            phase <= phase + 5'h01;
            if (phase == 5'h1F && duty != 5'h18) begin
                duty <= duty + 5'h01;
            end
            pwmLevel <= (phase < duty) ? `LVL_HIGH : `LVL_LOW;
        end
    end
endmodule // pwm_controller_model

// ===== test/tb.sv
`timescale 1ns/1ns
`include "gate_drive_defs.vh"
module tb;
    reg clock = 1'b0;
    reg rstn = 1'b0;
    reg clockEnable = 1'b1;
    reg supplyLockoutReleased = 1'b0;
    reg manual = 1'b1;
    reg [1:0] tbPulse = `LVL_HIGH;
    reg [1:0] conductionModeSelect = `LVL_HIGH;
    reg inductorCurrentPositive = 1'b0;
    reg lowSideGateBelowThreshold = 1'b1;
    reg switchNodeBelowThreshold = 1'b1;
    wire [1:0] ctrlPulse;
    wire [1:0] pulseLevel = manual ? tbPulse : ctrlPulse;
    wire highSideGate_r;
    wire lowSideGate_r;
    integer num_errors = 0;
    integer checks = 0;
    integer i, m, p, c;
    always #2 clock = ~clock;
    always @(posedge clock) begin
        lowSideGateBelowThreshold <= !lowSideGate_r;
        switchNodeBelowThreshold <= !highSideGate_r;
    end
    buck_gate_drive_control #(.TRI_HOLDOFF(8'h04), .LH_BLANK(8'h04), .HL_BLANK(8'h04)) u_dut (
        .clock(clock),
        .rstn(rstn),
        .clockEnable(clockEnable),
        .supplyLockoutReleased(supplyLockoutReleased),
        .pulseLevel(pulseLevel),
        .conductionModeSelect(conductionModeSelect),
        .lowSideGateBelowThreshold(lowSideGateBelowThreshold),
        .switchNodeBelowThreshold(switchNodeBelowThreshold),
        .inductorCurrentPositive(inductorCurrentPositive),
        .highSideGate_r(highSideGate_r),
        .lowSideGate_r(lowSideGate_r)
    );
    pwm_controller_model u_ctrl (.clock(clock), .rstn(rstn),
        .deviceReady(supplyLockoutReleased), .pwmLevel(ctrlPulse));
    function logic [1:0] expectGates(input integer m, input integer p, input integer c);
        if (m == 2 || p == 2) expectGates = 2'h0;
        else if (p == 1) expectGates = 2'h2;
        else if (m == 1 || c == 1) expectGates = 2'h1;
        else expectGates = 2'h0;
    endfunction
    task check(input logic [1:0] seen, input logic [1:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task report_and_stop;
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        void'($urandom(32'h68F26AB5));
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
        repeat (20) @(posedge clock);
        @(negedge clock);
        check({highSideGate_r, lowSideGate_r}, 2'h0);
        @(posedge clock);
        supplyLockoutReleased <= 1'b1;
        manual <= 1'b0;
        repeat (800) @(posedge clock);
        manual <= 1'b1;
        repeat (20) @(posedge clock);
        tbPulse <= `LVL_TRI;
        repeat (2) @(posedge clock);
        @(negedge clock);
        check({highSideGate_r, 1'b0}, 2'h2);
        for (i = 0; i < 60; i++) begin
            @(posedge clock);
            m = $urandom % 3;
            p = $urandom % 3;
            c = $urandom % 2;
            conductionModeSelect <= m[1:0];
            tbPulse <= p[1:0];
            inductorCurrentPositive <= c[0];
            repeat (20) @(posedge clock);
            @(negedge clock);
            check({highSideGate_r, lowSideGate_r}, expectGates(m, p, c));
        end
        report_and_stop;
    end
    initial begin
        #40000;
        num_errors++;
        report_and_stop;
    end
endmodule // tb
bind buck_gate_drive_control gate_drive_monitor u_mon (.*);
